// ==== design/asml_serial_port_unit.sv ====
// Added by the designer: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - software clearing tx empty flag makes holding data move into shift register
// - on that move, empty flag returns to one, sending starts, irq if enabled
// - frame opens with one low start bit, then 7 or 8 data bits lsb first
// - optional parity (even/odd) or address bit follows data; neither also allowed
// - one or two high stop bits, then line held high until next start
// - at stop bit, empty flag zero loads next data, next frame follows directly
// - empty flag one at stop bit sets tx end flag, line marks, irq if enabled
// - receiver finds low start bit, syncs, shifts data lsb first
// - with parity on, received ones count must match even/odd selection
// - first stop bit must be one; second stop bit is never checked
// - all checks pass sets rx full flag and copies shift into holding register
// - any error flag set halts reception until software clears error flags
// - rx full flag set raises rx full irq when rx irq enable is one
// - any error flag with rx irq enable raises rx error irq
// - frame completing while rx full flag is one flags overrun
// - stop bit zero flags framing error yet still loads received data
// - parity mismatch sets the parity error flag
// - address format sends the address bit value software set before clearing
// - address format ignores parity enable; no parity sent or checked
// - id wait enabled drops frames whose address bit is zero
// - receiver samples each bit on eighth of sixteen ticks, at bit centre
// - tx disable sets empty flag and resets shifter; rx disable keeps flags
// - format fields select length, parity, address mode, stop count: 16 formats
module asml_serial_port_unit
  import asml_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic rxd_in,
  output logic txd_out,
  output logic tx_empty_irq,
  output logic tx_end_irq,
  output logic rx_full_irq,
  output logic rx_error_irq
);

  // ==========================================
  // bus slave: zero wait states, always okay
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  wire addr_ok = hsel & htrans[1] & hready;
  wire [7:0] addr_lo = haddr[7:0];
  wire wr_txd = wr_pend_q & (wr_addr_q == ASML_OFF_TXDATA);
  wire wr_stat = wr_pend_q & (wr_addr_q == ASML_OFF_STATUS);
  wire wr_ctrl = wr_pend_q & (wr_addr_q == ASML_OFF_CTRL);
  wire wr_fmt = wr_pend_q & (wr_addr_q == ASML_OFF_FORMAT);
  wire wr_div = wr_pend_q & (wr_addr_q == ASML_OFF_DIVISOR);
  wire asml_status_t wstat = asml_status_t'(hwdata[7:0]);
  wire asml_ctrl_t wctrl = asml_ctrl_t'(hwdata[7:0]);

  asml_status_t stat_q;
  asml_status_t stat_d;
  asml_ctrl_t ctrl_q;
  asml_format_t fmt_q;
  logic [15:0] div_q;
  logic [7:0] tdr_q;
  logic [7:0] rdr_q;

  always_comb begin
    case (addr_lo)
      ASML_OFF_TXDATA: rd_mux = {24'h000000, tdr_q};
      ASML_OFF_RXDATA: rd_mux = {24'h000000, rdr_q};
      ASML_OFF_STATUS: rd_mux = {24'h000000, stat_q};
      ASML_OFF_CTRL: rd_mux = {24'h000000, ctrl_q};
      ASML_OFF_FORMAT: rd_mux = {24'h000000, fmt_q};
      ASML_OFF_DIVISOR: rd_mux = {16'h0000, div_q};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata_q <= 32'h00000000;
    end else begin
      wr_pend_q <= addr_ok & hwrite;
      wr_addr_q <= addr_lo;
      hrdata_q <= (addr_ok & ~hwrite) ? rd_mux : 32'h00000000;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================
  // configuration registers
  asml_ctrl_t ctrl_d;
  logic id_wait_clr;
  always_comb begin
    ctrl_d = ctrl_q;
    if (id_wait_clr) ctrl_d.id_wait_enable = 1'b0;
    if (wr_ctrl) begin
      ctrl_d = wctrl;
      ctrl_d.rsvd = 2'b00;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= ASML_CTRL_RST;
      fmt_q <= ASML_FORMAT_RST;
      div_q <= ASML_DIVISOR_RST;
      tdr_q <= ASML_TXDATA_RST;
    end else begin
      ctrl_q <= ctrl_d;
      if (wr_fmt) fmt_q <= {1'b0, hwdata[6:2], 2'b00};
      if (wr_div) div_q <= hwdata[15:0];
      if (wr_txd) tdr_q <= hwdata[7:0];
    end
  end

  // ==========================================
  // 16x tick from divisor: rate = hclk / (divisor + 1)
  logic [15:0] divcnt_q;
  wire tick = (divcnt_q == 16'h0000);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) divcnt_q <= 16'h0000;
    else divcnt_q <= tick ? div_q : divcnt_q - 16'h0001;
  end

  // ==========================================
  // format decode shared by both directions
  wire mp_fmt = fmt_q.mp_format_sel;
  wire extra_en = mp_fmt | fmt_q.parity_enable_bit;
  wire par_en = fmt_q.parity_enable_bit & ~mp_fmt;
  wire [2:0] idx_last = fmt_q.char_length_sel ? ASML_IDX_LAST7 : ASML_IDX_LAST8;
  wire [7:0] len_mask = fmt_q.char_length_sel ? 8'h7F : 8'hFF;

  // ==========================================
  // transmitter
  asml_tx_state_t tx_st_q;
  asml_tx_state_t tx_st_d;
  logic [7:0] tsr_q;
  logic tx_addr_bit_q;
  logic tx_pend_q;
  logic [3:0] tx_cnt_q;
  logic [2:0] tx_idx_q;
  logic txd_q;
  logic txd_d;
  logic tx_load;
  logic tx_end_set;
  logic pend_d;
  wire tx_on = ctrl_q.tx_enable_bit;
  wire tx_bit_done = tick & (tx_cnt_q == ASML_TICK_LAST);
  wire tx_par = ^(tsr_q & len_mask) ^ fmt_q.odd_parity_sel;
  wire tx_to_stop = tx_bit_done & ((tx_st_q == ASML_TX_EXTRA) |
                    ((tx_st_q == ASML_TX_DATA) & (tx_idx_q == idx_last) & ~extra_en));
  wire tx_start = tx_on & (tx_st_q == ASML_TX_IDLE) & ~stat_q.tx_holding_empty_flag;

  always_comb begin
    tx_st_d = tx_st_q;
    tx_load = tx_start;
    tx_end_set = 1'b0;
    pend_d = tx_pend_q;
    case (tx_st_q)
      ASML_TX_IDLE: if (tx_start) tx_st_d = ASML_TX_START;
      ASML_TX_START: if (tx_bit_done) tx_st_d = ASML_TX_DATA;
      ASML_TX_DATA: begin
        if (tx_bit_done && tx_idx_q == idx_last)
          tx_st_d = extra_en ? ASML_TX_EXTRA : ASML_TX_STOP1;
      end
      ASML_TX_EXTRA: if (tx_bit_done) tx_st_d = ASML_TX_STOP1;
      ASML_TX_STOP1: begin
        if (tx_bit_done)
          tx_st_d = fmt_q.two_stop_sel ? ASML_TX_STOP2 :
                    (tx_pend_q ? ASML_TX_START : ASML_TX_IDLE);
      end
      ASML_TX_STOP2: begin
        if (tx_bit_done) tx_st_d = tx_pend_q ? ASML_TX_START : ASML_TX_IDLE;
      end
      default: tx_st_d = ASML_TX_IDLE;
    endcase
    if (tx_to_stop) begin
      // empty flag is judged as the stop bit begins
      tx_load = ~stat_q.tx_holding_empty_flag;
      tx_end_set = stat_q.tx_holding_empty_flag;
      pend_d = ~stat_q.tx_holding_empty_flag;
    end else if (tx_st_d == ASML_TX_START) begin
      pend_d = 1'b0;
    end
    if (!tx_on) begin
      tx_st_d = ASML_TX_IDLE;
      tx_load = 1'b0;
      tx_end_set = 1'b0;
      pend_d = 1'b0;
    end
  end

  always_comb begin
    case (tx_st_q)
      ASML_TX_START: txd_d = 1'b0;
      ASML_TX_DATA: txd_d = tsr_q[tx_idx_q];
      ASML_TX_EXTRA: txd_d = mp_fmt ? tx_addr_bit_q : tx_par;
      default: txd_d = 1'b1;
    endcase
    // mark at once on disable, no stale bit left for a cycle
    if (!tx_on) txd_d = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_q <= ASML_TX_IDLE;
      tsr_q <= 8'hFF;
      tx_addr_bit_q <= 1'b0;
      tx_pend_q <= 1'b0;
      tx_cnt_q <= 4'h0;
      tx_idx_q <= 3'h0;
      txd_q <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tx_pend_q <= pend_d;
      txd_q <= txd_d;
      if (!tx_on) tsr_q <= 8'hFF;
      else if (tx_load) begin
        tsr_q <= tdr_q;
        tx_addr_bit_q <= stat_q.tx_addr_bit_value;
      end
      if (tx_st_q == ASML_TX_IDLE || tx_st_d != tx_st_q) tx_cnt_q <= 4'h0;
      else if (tick) tx_cnt_q <= tx_cnt_q + 4'h1;
      if (tx_st_q != ASML_TX_DATA) tx_idx_q <= 3'h0;
      else if (tx_bit_done) tx_idx_q <= tx_idx_q + 3'h1;
    end
  end

  assign txd_out = txd_q;

  // ==========================================
  // receiver
  asml_rx_state_t rx_st_q;
  asml_rx_state_t rx_st_d;
  logic [7:0] rsr_q;
  logic rx_extra_q;
  logic [3:0] rx_cnt_q;
  logic [2:0] rx_idx_q;
  wire rx_on = ctrl_q.rx_enable_bit;
  wire err_any = stat_q.overrun_flag | stat_q.framing_err_flag | stat_q.parity_err_flag;
  wire rx_bit_done = tick & (rx_cnt_q == ASML_TICK_LAST);
  wire rx_mid = tick & (rx_cnt_q == ASML_TICK_MID);
  wire rx_done = (rx_st_q == ASML_RX_STOP) & rx_bit_done;
  wire [7:0] rx_data = rsr_q & len_mask;
  wire skip = mp_fmt & ctrl_q.id_wait_enable & ~rx_extra_q;
  wire par_bad = par_en & ((^rx_data ^ rx_extra_q) != fmt_q.odd_parity_sel);
  wire stop_ok = rxd_in;
  wire ovr_ev = rx_done & ~skip & stat_q.rx_full_flag;
  wire frame_err_ev = rx_done & ~skip & ~stop_ok;
  wire per_ev = rx_done & ~skip & par_bad;
  // overrun drops the frame; framing error still hands data over
  wire rdr_load = rx_done & ~skip & ~stat_q.rx_full_flag & (~par_bad | ~stop_ok);
  wire rx_full_set = rx_done & ~skip & ~stat_q.rx_full_flag & stop_ok & ~par_bad;
  assign id_wait_clr = rx_done & mp_fmt & rx_extra_q;

  always_comb begin
    rx_st_d = rx_st_q;
    case (rx_st_q)
      ASML_RX_IDLE: if (tick && !rxd_in && !err_any) rx_st_d = ASML_RX_START;
      ASML_RX_START: begin
        // a glitch shorter than half a bit is not a start
        if (rx_mid) rx_st_d = rxd_in ? ASML_RX_IDLE : ASML_RX_DATA;
      end
      ASML_RX_DATA: begin
        if (rx_bit_done && rx_idx_q == idx_last)
          rx_st_d = extra_en ? ASML_RX_EXTRA : ASML_RX_STOP;
      end
      ASML_RX_EXTRA: if (rx_bit_done) rx_st_d = ASML_RX_STOP;
      ASML_RX_STOP: if (rx_bit_done) rx_st_d = ASML_RX_IDLE;
      default: rx_st_d = ASML_RX_IDLE;
    endcase
    if (!rx_on) rx_st_d = ASML_RX_IDLE;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_q <= ASML_RX_IDLE;
      rsr_q <= 8'h00;
      rx_extra_q <= 1'b0;
      rx_cnt_q <= 4'h0;
      rx_idx_q <= 3'h0;
      rdr_q <= 8'h00;
    end else begin
      rx_st_q <= rx_st_d;
      if (rx_st_q == ASML_RX_IDLE || rx_mid && rx_st_q == ASML_RX_START) rx_cnt_q <= 4'h0;
      else if (tick) rx_cnt_q <= rx_cnt_q + 4'h1;
      if (rx_st_q != ASML_RX_DATA) rx_idx_q <= 3'h0;
      else if (rx_bit_done) rx_idx_q <= rx_idx_q + 3'h1;
      if (rx_st_q == ASML_RX_START) rsr_q <= 8'h00;
      else if (rx_st_q == ASML_RX_DATA && rx_bit_done) rsr_q[rx_idx_q] <= rxd_in;
      if (rx_st_q == ASML_RX_START) rx_extra_q <= 1'b0;
      else if (rx_st_q == ASML_RX_EXTRA && rx_bit_done) rx_extra_q <= rxd_in;
      if (rdr_load) rdr_q <= rx_data;
    end
  end

  // ==========================================
  // status flags: software writes 0 to clear all but tx end and addr flag, hardware set wins
  always_comb begin
    stat_d = stat_q;
    if (wr_stat) begin
      stat_d.tx_addr_bit_value = wstat.tx_addr_bit_value;
      if (!wstat.tx_holding_empty_flag) stat_d.tx_holding_empty_flag = 1'b0;
      if (!wstat.rx_full_flag) stat_d.rx_full_flag = 1'b0;
      if (!wstat.overrun_flag) stat_d.overrun_flag = 1'b0;
      if (!wstat.framing_err_flag) stat_d.framing_err_flag = 1'b0;
      if (!wstat.parity_err_flag) stat_d.parity_err_flag = 1'b0;
    end
    if (tx_load) stat_d.tx_end_flag = 1'b0;
    if (tx_load || !tx_on) stat_d.tx_holding_empty_flag = 1'b1;
    if (tx_end_set) stat_d.tx_end_flag = 1'b1;
    if (rx_full_set) stat_d.rx_full_flag = 1'b1;
    if (rdr_load) stat_d.addr_flag_bit = rx_extra_q;
    if (ovr_ev) stat_d.overrun_flag = 1'b1;
    if (frame_err_ev) stat_d.framing_err_flag = 1'b1;
    if (per_ev) stat_d.parity_err_flag = 1'b1;
  end

  // ==========================================
  // interrupt requests, registered
  logic tx_empty_irq_q;
  logic tx_end_irq_q;
  logic rx_full_irq_q;
  logic rx_error_irq_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_q <= ASML_STATUS_RST;
      tx_empty_irq_q <= 1'b0;
      tx_end_irq_q <= 1'b0;
      rx_full_irq_q <= 1'b0;
      rx_error_irq_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      tx_empty_irq_q <= ctrl_d.tx_empty_irq_enable & stat_d.tx_holding_empty_flag;
      tx_end_irq_q <= ctrl_d.tx_end_irq_enable & stat_d.tx_end_flag;
      rx_full_irq_q <= ctrl_d.rx_irq_enable & stat_d.rx_full_flag;
      rx_error_irq_q <= ctrl_d.rx_irq_enable & (stat_d.overrun_flag |
                        stat_d.framing_err_flag | stat_d.parity_err_flag);
    end
  end

  assign tx_empty_irq = tx_empty_irq_q;
  assign tx_end_irq = tx_end_irq_q;
  assign rx_full_irq = rx_full_irq_q;
  assign rx_error_irq = rx_error_irq_q;

endmodule

// ==== design/asml_pkg.sv ====
package asml_pkg;

  // ==========================================
  // register map (byte addresses)
  localparam logic [7:0] ASML_OFF_TXDATA = 8'h00;
  localparam logic [7:0] ASML_OFF_RXDATA = 8'h04;
  localparam logic [7:0] ASML_OFF_STATUS = 8'h08;
  localparam logic [7:0] ASML_OFF_CTRL = 8'h0C;
  localparam logic [7:0] ASML_OFF_FORMAT = 8'h10;
  localparam logic [7:0] ASML_OFF_DIVISOR = 8'h14;

  // ==========================================
  // field layouts, msb first within the low byte
  typedef struct packed {
    logic tx_holding_empty_flag;
    logic rx_full_flag;
    logic overrun_flag;
    logic framing_err_flag;
    logic parity_err_flag;
    logic tx_end_flag;
    logic addr_flag_bit;
    logic tx_addr_bit_value;
  } asml_status_t;

  typedef struct packed {
    logic tx_empty_irq_enable;
    logic rx_irq_enable;
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic id_wait_enable;
    logic tx_end_irq_enable;
    logic [1:0] rsvd;
  } asml_ctrl_t;

  typedef struct packed {
    logic rsvd_hi;
    logic char_length_sel;
    logic parity_enable_bit;
    logic odd_parity_sel;
    logic two_stop_sel;
    logic mp_format_sel;
    logic [1:0] rsvd_lo;
  } asml_format_t;

  // ==========================================
  // reset values
  localparam asml_status_t ASML_STATUS_RST = 8'h84;
  localparam asml_ctrl_t ASML_CTRL_RST = 8'h00;
  localparam asml_format_t ASML_FORMAT_RST = 8'h00;
  localparam logic [15:0] ASML_DIVISOR_RST = 16'h0000;
  localparam logic [7:0] ASML_TXDATA_RST = 8'hFF;

  // ==========================================
  // timing: 16 ticks per bit, receiver samples on the eighth
  localparam logic [3:0] ASML_TICK_LAST = 4'hF;
  localparam logic [3:0] ASML_TICK_MID = 4'h7;
  localparam logic [2:0] ASML_IDX_LAST8 = 3'h7;
  localparam logic [2:0] ASML_IDX_LAST7 = 3'h6;

  // ==========================================
  // one-hot state codes
  typedef enum logic [5:0] {
    ASML_TX_IDLE = 6'b000001,
    ASML_TX_START = 6'b000010,
    ASML_TX_DATA = 6'b000100,
    ASML_TX_EXTRA = 6'b001000,
    ASML_TX_STOP1 = 6'b010000,
    ASML_TX_STOP2 = 6'b100000
  } asml_tx_state_t;

  typedef enum logic [4:0] {
    ASML_RX_IDLE = 5'b00001,
    ASML_RX_START = 5'b00010,
    ASML_RX_DATA = 5'b00100,
    ASML_RX_EXTRA = 5'b01000,
    ASML_RX_STOP = 5'b10000
  } asml_rx_state_t;

endpackage

// ==== testbench/asml_serial_port_unit_assertions.sv ====
`timescale 1ns/1ps
// ==========================================
// port checks; low-run figures assume divisor 0
module asml_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic txd_out,
  input wire logic tx_empty_irq,
  input wire logic tx_end_irq,
  input wire logic rx_full_irq,
  input wire logic rx_error_irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_dp_q;
  logic rd_dp_q;
  logic [7:0] low_q;
  wire take = hsel & htrans[1] & hready;
  // saturate so a stuck line cannot wrap into a legal count
  wire [7:0] low_d = txd_out ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_q <= 1'b0;
      rd_dp_q <= 1'b0;
      low_q <= 8'h00;
    end else begin
      wr_dp_q <= take & hwrite;
      rd_dp_q <= take & ~hwrite;
      low_q <= low_d;
    end
  end
  sequence s_unmap_rd;
    take && !hwrite && haddr[7:0] > 8'h17;
  endsequence
  sequence s_mark8;
    txd_out [*8];
  endsequence
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_idle_zero;
    !rd_dp_q |-> hrdata == 32'h0;
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data outside data phase");
  property p_hi_zero;
    hrdata[31:16] == 16'h0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
  property p_unmap;
    s_unmap_rd |=> hrdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_end_mark;
    $rose(tx_end_irq) |=> s_mark8;
  endproperty
  a_end_mark: assert property (p_end_mark) else $error("line not marking at end");
  property p_low_whole;
    $rose(txd_out) |-> low_q[3:0] == 4'h0;
  endproperty
  a_low_whole: assert property (p_low_whole) else $error("partial bit time");
  property p_low_max;
    $rose(txd_out) |-> low_q <= 8'hA0;
  endproperty
  a_low_max: assert property (p_low_max) else $error("low past stop bit");
  property p_txe_fall;
    $fell(tx_empty_irq) |-> $past(wr_dp_q);
  endproperty
  a_txe_fall: assert property (p_txe_fall) else $error("tx empty dropped alone");
  property p_rxf_fall;
    $fell(rx_full_irq) |-> $past(wr_dp_q);
  endproperty
  a_rxf_fall: assert property (p_rxf_fall) else $error("rx full dropped alone");
  property p_rxe_fall;
    $fell(rx_error_irq) |-> $past(wr_dp_q);
  endproperty
  a_rxe_fall: assert property (p_rxe_fall) else $error("rx error dropped alone");
endmodule

bind asml_serial_port_unit asml_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .txd_out(txd_out), .tx_empty_irq(tx_empty_irq),
  .tx_end_irq(tx_end_irq), .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq));

// ==== testbench/asml_peer.sv ====
`timescale 1ns/1ps
// ==========================================
// remote serial node
module asml_peer (
  input wire logic hclk,
  input wire logic txd_out,
  output logic rxd_in
);
  // pulled-up line: marks between frames
  initial rxd_in = 1'b1;
  task automatic send(input logic [11:0] v, input int n);
    @(posedge hclk);
    for (int i = 0; i < n; i++) begin
      rxd_in <= v[i];
      repeat (16) @(posedge hclk);
    end
    rxd_in <= 1'b1;
  endtask
  // samples at bit centre, away from the launching edge
  task automatic capture(input int n, output logic [11:0] v, output int gap);
    gap = 0;
    v = 12'hFFF;
    @(negedge hclk);
    while (txd_out !== 1'b0) begin
      gap++;
      @(negedge hclk);
    end
    repeat (8) @(negedge hclk);
    for (int i = 0; i < n; i++) begin
      v[i] = txd_out;
      if (i < n - 1) repeat (16) @(negedge hclk);
    end
  endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
// ==========================================
// bench top
module tb;
  import asml_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, txd_out, rxd_in;
  logic tx_empty_irq, tx_end_irq, rx_full_irq, rx_error_irq;
  int mismatches = 0;
  int comparisons = 0;
  always #50 hclk = ~hclk;
  asml_serial_port_unit i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd_in(rxd_in),
    .txd_out(txd_out), .tx_empty_irq(tx_empty_irq), .tx_end_irq(tx_end_irq),
    .rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq));
  asml_peer i_peer (.hclk(hclk), .txd_out(txd_out), .rxd_in(rxd_in));
  // ==========================================
  // helpers
  function automatic logic [11:0] frame(input logic [7:0] d, input logic [7:0] f,
    input logic ab, input logic bp, input logic bs, output int n);
    logic [11:0] v;
    int nd;
    v = 12'hFFF;
    nd = f[6] ? 7 : 8;
    v[0] = 1'b0;
    for (int i = 0; i < nd; i++) v[1 + i] = d[i];
    n = 1 + nd;
    if (f[2]) begin
      v[n] = ab;
      n++;
    end else if (f[5]) begin
      v[n] = ^(d & (f[6] ? 8'h7F : 8'hFF)) ^ f[4] ^ bp;
      n++;
    end
    v[n] = ~bs;
    n = n + (f[3] ? 2 : 1);
    return v;
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask
  task automatic sts(input string nm, input logic [3:0] e);
    logic [31:0] x;
    bus(1'b0, ASML_OFF_STATUS, 32'h0, x);
    chk(nm, 32'(e), 32'(x[6:3]));
  endtask
  task automatic rx(input logic [7:0] d, input logic [7:0] f, input logic ab,
    input logic bp, input logic bs);
    int n;
    logic [11:0] v;
    v = frame(d, f, ab, bp, bs, n);
    i_peer.send(v, n);
  endtask
  task automatic conclude;
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    rchk("status", ASML_OFF_STATUS, {24'h0, ASML_STATUS_RST});
    rchk("ctrl", ASML_OFF_CTRL, {24'h0, ASML_CTRL_RST});
    rchk("format", ASML_OFF_FORMAT, {24'h0, ASML_FORMAT_RST});
    rchk("txdata", ASML_OFF_TXDATA, {24'h0, ASML_TXDATA_RST});
    rchk("divisor", ASML_OFF_DIVISOR, {16'h0, ASML_DIVISOR_RST});
    wr(ASML_OFF_DIVISOR, 32'h00000003);
    rchk("divisor rw", ASML_OFF_DIVISOR, 32'h00000003);
    wr(ASML_OFF_DIVISOR, 32'h00000000);
    wr(ASML_OFF_RXDATA, 32'hFF);
    rchk("rxdata", ASML_OFF_RXDATA, 32'h0);
    rchk("unmapped", 8'h18, 32'h0);
  endtask
  task automatic t_tx;
    logic [7:0] fm[6] = '{8'h00, 8'h28, 8'h70, 8'h0C, 8'h64, 8'h48};
    logic [11:0] v, e;
    int n, g;
    wr(ASML_OFF_CTRL, 32'hA4);
    foreach (fm[i]) begin
      wr(ASML_OFF_FORMAT, {24'h0, fm[i]});
      e = frame(8'hA5, fm[i], i[0], 1'b0, 1'b0, n);
      fork
        i_peer.capture(n, v, g);
        begin
          wr(ASML_OFF_TXDATA, 32'hA5);
          wr(ASML_OFF_STATUS, {31'h3F, i[0]});
        end
      join
      chk("tx frame", 32'(e), 32'(v));
      chk("tx empty irq", 32'h1, 32'(tx_empty_irq));
      repeat (10) @(posedge hclk);
    end
  endtask
  task automatic t_b2b;
    logic [11:0] v;
    logic [31:0] x;
    int n, g;
    wr(ASML_OFF_FORMAT, 32'h0);
    fork
      i_peer.capture(10, v, g);
      begin
        wr(ASML_OFF_TXDATA, 32'h11);
        wr(ASML_OFF_STATUS, 32'h7E);
        wr(ASML_OFF_TXDATA, 32'h22);
        wr(ASML_OFF_STATUS, 32'h7E);
      end
    join
    chk("frame a", 32'(frame(8'h11, 8'h0, 1'b0, 1'b0, 1'b0, n)), 32'(v));
    chk("early end", 32'h0, 32'(tx_end_irq));
    i_peer.capture(10, v, g);
    chk("frame b", 32'(frame(8'h22, 8'h0, 1'b0, 1'b0, 1'b0, n)), 32'(v));
    chk("gap", 32'h1, 32'(g < 16));
    chk("tx end irq", 32'h1, 32'(tx_end_irq));
    wr(ASML_OFF_TXDATA, 32'h33);
    wr(ASML_OFF_STATUS, 32'h7E);
    wr(ASML_OFF_TXDATA, 32'h44);
    wr(ASML_OFF_STATUS, 32'h7E);
    repeat (40) @(posedge hclk);
    wr(ASML_OFF_CTRL, 32'h84);
    bus(1'b0, ASML_OFF_STATUS, 32'h0, x);
    chk("tx off empty", 32'h1, 32'(x[7]));
    @(negedge hclk);
    chk("tx off line", 32'h1, 32'(txd_out));
  endtask
  task automatic t_rx;
    wr(ASML_OFF_FORMAT, 32'h20);
    wr(ASML_OFF_CTRL, 32'h50);
    rx(8'h3C, 8'h20, 1'b0, 1'b0, 1'b0);
    rchk("rxdata", ASML_OFF_RXDATA, 32'h3C);
    chk("rx full irq", 32'h1, 32'(rx_full_irq));
    rx(8'h5A, 8'h20, 1'b0, 1'b0, 1'b0);
    sts("overrun", 4'hC);
    chk("rx err irq", 32'h1, 32'(rx_error_irq));
    rx(8'h77, 8'h20, 1'b0, 1'b0, 1'b0);
    rchk("kept data", ASML_OFF_RXDATA, 32'h3C);
    wr(ASML_OFF_CTRL, 32'h40);
    sts("rx off flags", 4'hC);
    wr(ASML_OFF_CTRL, 32'h50);
    wr(ASML_OFF_STATUS, 32'h87);
    @(negedge hclk);
    chk("err cleared", 32'h0, 32'(rx_error_irq));
    rx(8'h66, 8'h20, 1'b0, 1'b0, 1'b1);
    rchk("framing data", ASML_OFF_RXDATA, 32'h66);
    sts("framing", 4'h2);
    wr(ASML_OFF_STATUS, 32'h87);
    rx(8'h99, 8'h20, 1'b0, 1'b1, 1'b0);
    sts("parity", 4'h1);
    wr(ASML_OFF_STATUS, 32'h87);
    wr(ASML_OFF_FORMAT, 32'h38);
    rx(8'h81, 8'h38, 1'b0, 1'b0, 1'b0);
    rchk("odd data", ASML_OFF_RXDATA, 32'h81);
    sts("odd flags", 4'h8);
    wr(ASML_OFF_STATUS, 32'h87);
  endtask
  task automatic t_mp;
    logic [31:0] x;
    wr(ASML_OFF_FORMAT, 32'h04);
    wr(ASML_OFF_CTRL, 32'h58);
    rx(8'h12, 8'h04, 1'b0, 1'b0, 1'b0);
    chk("dropped", 32'h0, 32'(rx_full_irq));
    rx(8'h34, 8'h04, 1'b1, 1'b0, 1'b0);
    rchk("id data", ASML_OFF_RXDATA, 32'h34);
    bus(1'b0, ASML_OFF_CTRL, 32'h0, x);
    chk("id wait", 32'h0, 32'(x[3]));
    bus(1'b0, ASML_OFF_STATUS, 32'h0, x);
    chk("addr bit", 32'h1, 32'(x[1]));
    wr(ASML_OFF_STATUS, 32'h87);
    rx(8'h56, 8'h04, 1'b0, 1'b0, 1'b0);
    rchk("mp data", ASML_OFF_RXDATA, 32'h56);
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_tx;
    t_b2b;
    t_rx;
    t_mp;
    conclude;
  end
  // roughly twelve times the expected run
  initial begin
    repeat (40000) @(posedge hclk);
    mismatches++;
    conclude;
  end
endmodule
